// ### hfdc_chk.sv
// port-level assertions for the host fifo datapath control block
`timescale 1ns/1ps
module hfdc_chk #(
	parameter DAW = 6,
	parameter SAW = 4
) (
	input wire CLK,
	input wire ARST_N,
	input wire TX_WR,
	input wire TX_DFIFO_FULL,
	input wire TX_STAT_PUSH,
	input wire TX_STAT_FULL,
	input wire TX_STATUS_DISCARD_ALLOW_OVERRUN,
	input wire TX_ERR_CLR,
	input wire TRANSMIT_ERROR_FLAG,
	input wire TX_FRAME_BUSY,
	input wire TX_ON,
	input wire TX_STOP,
	input wire TRANSMIT_HALTED_INTERRUPT,
	input wire RX_SKIP_HEAD_PACKET_SET,
	input wire RX_SKIP_HEAD_PACKET,
	input wire RX_DUMP_SET,
	input wire RX_DUMP,
	input wire HOST_RD_STAT,
	input wire [DAW:0] RX_QUEUE_FILL_DATA,
	input wire [SAW:0] RX_QUEUE_FILL_STAT,
	input wire RX_ERR_CLR,
	input wire RECEIVE_ERROR_FLAG
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence stop_done;
		TX_STOP && (TX_STAT_PUSH || !TX_FRAME_BUSY);
	endsequence
	sequence halt_once;
		TRANSMIT_HALTED_INTERRUPT && !TX_STOP && !TX_ON ##1 !TRANSMIT_HALTED_INTERRUPT;
	endsequence
	chk_halt_pulse: assert property (stop_done |=> halt_once)
		else $error("halt pulse wrong");
	chk_stop_waits: assert property (TX_STOP && TX_FRAME_BUSY && !TX_STAT_PUSH |=> TX_STOP && !TRANSMIT_HALTED_INTERRUPT)
		else $error("stop before frame end");
	chk_halt_cause: assert property ($rose(TRANSMIT_HALTED_INTERRUPT) |-> $past(TX_STOP))
		else $error("halt without stop");
	chk_data_overrun: assert property (TX_WR && TX_DFIFO_FULL |=> TRANSMIT_ERROR_FLAG)
		else $error("data overrun not flagged");
	chk_stat_overrun: assert property (TX_STAT_PUSH && TX_STAT_FULL && !TX_STATUS_DISCARD_ALLOW_OVERRUN
		|=> TRANSMIT_ERROR_FLAG)
		else $error("status overrun not flagged");
	chk_err_cause: assert property ($rose(TRANSMIT_ERROR_FLAG) |-> $past(TX_WR)
		|| $past(TX_STAT_PUSH && TX_STAT_FULL && !TX_STATUS_DISCARD_ALLOW_OVERRUN))
		else $error("error without cause");
	chk_err_sticky: assert property (TRANSMIT_ERROR_FLAG && !TX_ERR_CLR |=> TRANSMIT_ERROR_FLAG)
		else $error("tx error dropped");
	chk_err_clear: assert property (TX_ERR_CLR && !TX_WR && !TX_STAT_PUSH |=> !TRANSMIT_ERROR_FLAG)
		else $error("tx error not cleared");
	chk_rx_underrun: assert property (HOST_RD_STAT && RX_QUEUE_FILL_STAT == 0 |=> RECEIVE_ERROR_FLAG)
		else $error("underrun not flagged");
	chk_rxe_sticky: assert property (RECEIVE_ERROR_FLAG && !RX_ERR_CLR |=> RECEIVE_ERROR_FLAG)
		else $error("rx error dropped");
	chk_dump_run: assert property (RX_DUMP_SET |=> RX_DUMP ##1 (!RX_DUMP && RX_QUEUE_FILL_DATA == 0
		&& RX_QUEUE_FILL_STAT == 0))
		else $error("dump wrong");
	chk_skip_bound: assert property (RX_SKIP_HEAD_PACKET_SET |=> RX_SKIP_HEAD_PACKET ##[1:80] !RX_SKIP_HEAD_PACKET)
		else $error("skip not done");
	chk_skip_stat: assert property (RX_SKIP_HEAD_PACKET && !HOST_RD_STAT
		|=> RX_QUEUE_FILL_STAT >= $past(RX_QUEUE_FILL_STAT))
		else $error("skip hit status");
endmodule // hfdc_chk
bind hfdc_top hfdc_chk #(.DAW(DAW), .SAW(SAW)) hfdc_chk_i (.*);

// ### hfdc_mac_model.sv
// mac side word source feeding the receive path
`timescale 1ns/1ps
module hfdc_mac_model (
	input wire CLK,
	input wire MAC_READY,
	output reg MAC_VALID,
	output reg [31:0] MAC_DATA,
	output reg MAC_LAST,
	output reg [1:0] MAC_LAST_BYTES,
	output reg MAC_IS_STATUS
);
	initial begin
		MAC_VALID = 1'b0;
		MAC_DATA = 32'h00000000;
		MAC_LAST = 1'b0;
		MAC_LAST_BYTES = 2'h0;
		MAC_IS_STATUS = 1'b0;
	end
	// holds the word until taken; ok low after 40 refused edges
	task send(input [31:0] d, input l, input [1:0] lb, input s, output ok);
		integer n;
		begin
			@(negedge CLK);
			MAC_VALID = 1'b1;
			MAC_DATA = d;
			MAC_LAST = l;
			MAC_LAST_BYTES = lb;
			MAC_IS_STATUS = s;
			ok = 1'b0;
			for (n = 0; n < 40 && !ok; n = n + 1) begin
				@(posedge CLK);
				ok = (MAC_READY === 1'b1);
			end
		end
	endtask
	task idle;
		begin
			@(negedge CLK);
			MAC_VALID = 1'b0;
			MAC_DATA = ~MAC_DATA;
		end
	endtask
endmodule // hfdc_mac_model

// ### hfdc_regs.vh
// constants for the host fifo datapath control block
`ifndef HFDC_REGS_VH
`define HFDC_REGS_VH
// first transmit command word fields
`define HFDC_A_BUFSZ_MSB 10
`define HFDC_A_LS_BIT 12
`define HFDC_A_FS_BIT 13
// second transmit command word fields
`define HFDC_B_PKTLEN_MSB 10
// receive start offset field
`define HFDC_OFF_WORD_MSB 4
`define HFDC_OFF_WORD_LSB 2
// default fifo sizes and burst length
`define HFDC_DATA_AW 6
`define HFDC_STAT_AW 4
`define HFDC_BURST_WORDS 8'h04
// skid entry layout
`define HFDC_SK_W 36
`define HFDC_SK_LAST 32
`define HFDC_SK_LB_LSB 33
`define HFDC_SK_LB_MSB 34
`define HFDC_SK_STAT 35
// transmit parser phases
`define HFDC_TXP_A 3'h1
`define HFDC_TXP_B 3'h2
`define HFDC_TXP_D 3'h4
// receive formatter states
`define HFDC_FMT_IDLE 5'h01
`define HFDC_FMT_LEAD 5'h02
`define HFDC_FMT_BODY 5'h04
`define HFDC_FMT_FLUSH 5'h08
`define HFDC_FMT_PAD 5'h10
// reset values
`define HFDC_RST_FLAG 1'h0
`define HFDC_RST_WORD 32'h00000000
`endif

// ### hfdc_skid.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module hfdc_skid #(
	parameter W = 36
) (
	input wire clk,
	input wire arst_n,
	input wire in_valid,
	input wire [W-1:0] in_data,
	output wire in_ready,
	output wire out_valid,
	output wire [W-1:0] out_data,
	input wire out_ready
);
	reg [W-1:0] e0_reg;
	reg [W-1:0] e1_reg;
	reg [1:0] cnt_reg;
	reg [1:0] cnt_next;
	reg rdy_reg;
	wire push;
	wire pop;
	assign push = in_valid & rdy_reg;
	assign pop = out_valid & out_ready;
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = e0_reg;
	assign in_ready = rdy_reg;
	always @* begin
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 2'h1;
		else if (pop && !push)
			cnt_next = cnt_reg - 2'h1;
	end
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			e0_reg <= {W{1'b0}};
			e1_reg <= {W{1'b0}};
			cnt_reg <= 2'h0;
			rdy_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			rdy_reg <= (cnt_next != 2'h2);
			if (push && pop) begin
				if (cnt_reg == 2'h1) begin
					e0_reg <= in_data;
				end else begin
					e0_reg <= e1_reg;
					e1_reg <= in_data;
				end
			end else if (push) begin
				if (cnt_reg == 2'h0)
					e0_reg <= in_data;
				else
					e1_reg <= in_data;
			end else if (pop) begin
				e0_reg <= e1_reg;
			end
		end
	end
endmodule // hfdc_skid

// ### hfdc_top.v
// host fifo datapath control: transmit error and stop logic, receive data and status queues
`timescale 1ns/1ps
`include "hfdc_regs.vh"
module hfdc_top #(
	parameter DAW = `HFDC_DATA_AW,
	parameter SAW = `HFDC_STAT_AW,
	parameter [7:0] RX_BURST_WORDS = `HFDC_BURST_WORDS
) (
	input wire CLK,
	input wire ARST_N,
	input wire TX_WR,
	input wire [31:0] TX_WDATA,
	input wire TX_DFIFO_FULL,
	input wire TX_STAT_PUSH,
	input wire TX_STAT_FULL,
	input wire TX_STATUS_DISCARD_ALLOW_OVERRUN,
	input wire TX_ERR_CLR,
	output reg TRANSMIT_ERROR_FLAG,
	input wire TX_STOP_SET,
	input wire TX_ON_SET,
	input wire TX_FRAME_BUSY,
	output reg TX_ON,
	output reg TX_STOP,
	output reg TRANSMIT_HALTED_INTERRUPT,
	input wire MAC_VALID,
	input wire [31:0] MAC_DATA,
	input wire MAC_LAST,
	input wire [1:0] MAC_LAST_BYTES,
	input wire MAC_IS_STATUS,
	output wire MAC_READY,
	input wire [4:0] RX_OFFSET,
	input wire RX_PAD_EN,
	input wire RX_SKIP_HEAD_PACKET_SET,
	output reg RX_SKIP_HEAD_PACKET,
	input wire RX_DUMP_SET,
	output reg RX_DUMP,
	input wire HOST_RD_DATA,
	input wire HOST_RD_STAT,
	output reg [31:0] RX_RDATA,
	output reg [31:0] RX_RSTAT,
	output reg [DAW:0] RX_QUEUE_FILL_DATA,
	output reg [SAW:0] RX_QUEUE_FILL_STAT,
	input wire RX_ERR_CLR,
	output reg RECEIVE_ERROR_FLAG
);
	localparam DDEPTH = 1 << DAW;
	localparam SDEPTH = 1 << SAW;
	localparam [7:0] BMASK = RX_BURST_WORDS - 8'h01;

	// transmit command parser
	reg [2:0] txp_reg;
	reg [10:0] buf_bytes_reg;
	reg ls_reg;
	reg [9:0] words_left_reg;
	reg [31:0] cmd_b_reg;
	reg [15:0] acc_reg;
	reg len_err;
	reg b_err;
	wire tx_take;
	wire [9:0] a_words;
	wire [15:0] acc_sum;
	wire buf_end_b;
	wire buf_end_d;
	assign tx_take = TX_WR & ~TX_DFIFO_FULL;
	assign a_words = {1'b0, TX_WDATA[`HFDC_A_BUFSZ_MSB:2]} + {9'h000, (TX_WDATA[1:0] != 2'h0)};
	assign acc_sum = acc_reg + {5'h00, buf_bytes_reg};
	assign buf_end_b = tx_take && txp_reg == `HFDC_TXP_B && words_left_reg == 10'h000;
	assign buf_end_d = tx_take && txp_reg == `HFDC_TXP_D && words_left_reg == 10'h001;
	always @* begin
		len_err = 1'b0;
		b_err = 1'b0;
		if ((buf_end_b || buf_end_d) && ls_reg)
			len_err = (acc_sum != {5'h00, cmd_b_reg[`HFDC_B_PKTLEN_MSB:0]});
		if (tx_take && txp_reg == `HFDC_TXP_B && acc_reg != 16'h0000)
			b_err = (TX_WDATA != cmd_b_reg);
	end
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			txp_reg <= `HFDC_TXP_A;
			buf_bytes_reg <= 11'h000;
			ls_reg <= 1'b0;
			words_left_reg <= 10'h000;
			cmd_b_reg <= `HFDC_RST_WORD;
			acc_reg <= 16'h0000;
		end else if (tx_take) begin
			case (txp_reg)
				`HFDC_TXP_A: begin
					buf_bytes_reg <= TX_WDATA[`HFDC_A_BUFSZ_MSB:0];
					ls_reg <= TX_WDATA[`HFDC_A_LS_BIT];
					words_left_reg <= a_words;
					if (TX_WDATA[`HFDC_A_FS_BIT])
						acc_reg <= 16'h0000;
					txp_reg <= `HFDC_TXP_B;
				end
				`HFDC_TXP_B: begin
					if (acc_reg == 16'h0000)
						cmd_b_reg <= TX_WDATA;
					if (buf_end_b) begin
						acc_reg <= ls_reg ? 16'h0000 : acc_sum;
						txp_reg <= `HFDC_TXP_A;
					end else begin
						txp_reg <= `HFDC_TXP_D;
					end
				end
				`HFDC_TXP_D: begin
					words_left_reg <= words_left_reg - 10'h001;
					if (buf_end_d) begin
						acc_reg <= ls_reg ? 16'h0000 : acc_sum;
						txp_reg <= `HFDC_TXP_A;
					end
				end
				default: txp_reg <= `HFDC_TXP_A;
			endcase
		end
	end

	// transmit error flag and stop handshake
	wire tx_err_set;
	wire stop_done;
	assign tx_err_set = len_err | b_err | (TX_WR & TX_DFIFO_FULL)
		| (TX_STAT_PUSH & TX_STAT_FULL & ~TX_STATUS_DISCARD_ALLOW_OVERRUN);
	assign stop_done = TX_STOP & (TX_STAT_PUSH | ~TX_FRAME_BUSY);
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TRANSMIT_ERROR_FLAG <= `HFDC_RST_FLAG;
			TX_ON <= `HFDC_RST_FLAG;
			TX_STOP <= `HFDC_RST_FLAG;
			TRANSMIT_HALTED_INTERRUPT <= `HFDC_RST_FLAG;
		end else begin
			TRANSMIT_ERROR_FLAG <= tx_err_set | (TRANSMIT_ERROR_FLAG & ~TX_ERR_CLR);
			TRANSMIT_HALTED_INTERRUPT <= stop_done;
			if (stop_done) begin
				TX_STOP <= 1'b0;
				TX_ON <= 1'b0;
			end else begin
				TX_STOP <= TX_STOP | TX_STOP_SET;
				TX_ON <= TX_ON | TX_ON_SET;
			end
		end
	end

	// receive input buffer from the mac side
	wire sk_valid;
	wire [`HFDC_SK_W-1:0] sk_data;
	reg sk_ready;
	hfdc_skid #(.W(`HFDC_SK_W)) u_skid (
		.clk(CLK),
		.arst_n(ARST_N),
		.in_valid(MAC_VALID),
		.in_data({MAC_IS_STATUS, MAC_LAST_BYTES, MAC_LAST, MAC_DATA}),
		.in_ready(MAC_READY),
		.out_valid(sk_valid),
		.out_data(sk_data),
		.out_ready(sk_ready)
	);
	wire s_stat;
	wire s_last;
	wire [2:0] s_lbn;
	assign s_stat = sk_data[`HFDC_SK_STAT];
	assign s_last = sk_data[`HFDC_SK_LAST];
	assign s_lbn = (sk_data[`HFDC_SK_LB_MSB:`HFDC_SK_LB_LSB] == 2'h0) ? 3'h4
		: {1'b0, sk_data[`HFDC_SK_LB_MSB:`HFDC_SK_LB_LSB]};

	// receive fifos
	reg [32:0] dmem [0:DDEPTH-1];
	reg [31:0] smem [0:SDEPTH-1];
	reg [DAW-1:0] dwr_reg;
	reg [DAW-1:0] drd_reg;
	reg [SAW-1:0] swr_reg;
	reg [SAW-1:0] srd_reg;
	wire dfull;
	wire sfull;
	wire dempty;
	wire sempty;
	assign dfull = RX_QUEUE_FILL_DATA[DAW];
	assign sfull = RX_QUEUE_FILL_STAT[SAW];
	assign dempty = (RX_QUEUE_FILL_DATA == {(DAW+1){1'b0}});
	assign sempty = (RX_QUEUE_FILL_STAT == {(SAW+1){1'b0}});

	// receive formatter: offset, shift, flush, pad
	reg [4:0] fmt_reg;
	reg [4:0] fmt_next;
	reg [4:0] off_reg;
	reg [4:0] off_next;
	reg [2:0] lead_reg;
	reg [2:0] lead_next;
	reg [31:0] carry_reg;
	reg [31:0] carry_next;
	reg [7:0] wc_reg;
	reg [7:0] wc_next;
	reg dpush;
	reg [31:0] dword;
	reg dlast;
	reg spush;
	wire [1:0] bsh;
	wire [7:0] wc_inc;
	wire pad_need;
	wire [31:0] shifted;
	assign bsh = off_reg[1:0];
	assign wc_inc = wc_reg + 8'h01;
	assign pad_need = RX_PAD_EN && ((wc_inc & BMASK) != 8'h00);
	assign shifted = (sk_data[31:0] << {bsh, 3'h0}) | carry_reg;
	always @* begin
		fmt_next = fmt_reg;
		off_next = off_reg;
		lead_next = lead_reg;
		carry_next = carry_reg;
		wc_next = wc_reg;
		sk_ready = 1'b0;
		dpush = 1'b0;
		dword = `HFDC_RST_WORD;
		dlast = 1'b0;
		spush = 1'b0;
		case (fmt_reg)
			`HFDC_FMT_IDLE: begin
				if (sk_valid && s_stat) begin
					if (!sfull) begin
						spush = 1'b1;
						sk_ready = 1'b1;
					end
				end else if (sk_valid) begin
					off_next = RX_OFFSET;
					lead_next = RX_OFFSET[`HFDC_OFF_WORD_MSB:`HFDC_OFF_WORD_LSB];
					carry_next = `HFDC_RST_WORD;
					wc_next = 8'h00;
					fmt_next = (RX_OFFSET[`HFDC_OFF_WORD_MSB:`HFDC_OFF_WORD_LSB] != 3'h0)
						? `HFDC_FMT_LEAD : `HFDC_FMT_BODY;
				end
			end
			`HFDC_FMT_LEAD: begin
				if (!dfull) begin
					dpush = 1'b1;
					wc_next = wc_inc;
					lead_next = lead_reg - 3'h1;
					if (lead_reg == 3'h1)
						fmt_next = `HFDC_FMT_BODY;
				end
			end
			`HFDC_FMT_BODY: begin
				if (sk_valid && !s_stat && !dfull) begin
					sk_ready = 1'b1;
					dpush = 1'b1;
					dword = shifted;
					wc_next = wc_inc;
					carry_next = (bsh == 2'h0) ? `HFDC_RST_WORD : (sk_data[31:0] >> (6'h20 - {1'b0, bsh, 3'h0}));
					if (s_last) begin
						if (bsh != 2'h0 && ({1'b0, s_lbn} + {2'h0, bsh}) > 4'h4)
							fmt_next = `HFDC_FMT_FLUSH;
						else if (pad_need)
							fmt_next = `HFDC_FMT_PAD;
						else begin
							dlast = 1'b1;
							fmt_next = `HFDC_FMT_IDLE;
						end
					end
				end
			end
			`HFDC_FMT_FLUSH: begin
				if (!dfull) begin
					dpush = 1'b1;
					dword = carry_reg;
					wc_next = wc_inc;
					if (pad_need)
						fmt_next = `HFDC_FMT_PAD;
					else begin
						dlast = 1'b1;
						fmt_next = `HFDC_FMT_IDLE;
					end
				end
			end
			`HFDC_FMT_PAD: begin
				if (!dfull) begin
					dpush = 1'b1;
					wc_next = wc_inc;
					if (!pad_need) begin
						dlast = 1'b1;
						fmt_next = `HFDC_FMT_IDLE;
					end
				end
			end
			default: fmt_next = `HFDC_FMT_IDLE;
		endcase
	end
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fmt_reg <= `HFDC_FMT_IDLE;
			off_reg <= 5'h00;
			lead_reg <= 3'h0;
			carry_reg <= `HFDC_RST_WORD;
			wc_reg <= 8'h00;
		end else begin
			fmt_reg <= fmt_next;
			off_reg <= off_next;
			lead_reg <= lead_next;
			carry_reg <= carry_next;
			wc_reg <= wc_next;
		end
	end

	// queue pointers, skip, dump and host reads
	wire d_wr;
	wire s_wr;
	wire host_d_rd;
	wire host_s_rd;
	wire skip_pop;
	wire skip_done;
	wire d_rd;
	wire rx_err_set;
	assign d_wr = dpush & ~RX_DUMP;
	assign s_wr = spush & ~RX_DUMP;
	assign host_d_rd = HOST_RD_DATA & ~RX_SKIP_HEAD_PACKET & ~dempty;
	assign host_s_rd = HOST_RD_STAT & ~sempty;
	assign skip_pop = RX_SKIP_HEAD_PACKET & ~dempty;
	assign skip_done = skip_pop & dmem[drd_reg][32];
	assign d_rd = host_d_rd | skip_pop;
	assign rx_err_set = (HOST_RD_DATA & ~RX_SKIP_HEAD_PACKET & dempty) | (HOST_RD_STAT & sempty);
	always @(posedge CLK) begin
		if (d_wr)
			dmem[dwr_reg] <= {dlast, dword};
		if (s_wr)
			smem[swr_reg] <= sk_data[31:0];
	end
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dwr_reg <= {DAW{1'b0}};
			drd_reg <= {DAW{1'b0}};
			swr_reg <= {SAW{1'b0}};
			srd_reg <= {SAW{1'b0}};
			RX_QUEUE_FILL_DATA <= {(DAW+1){1'b0}};
			RX_QUEUE_FILL_STAT <= {(SAW+1){1'b0}};
			RX_RDATA <= `HFDC_RST_WORD;
			RX_RSTAT <= `HFDC_RST_WORD;
			RX_SKIP_HEAD_PACKET <= `HFDC_RST_FLAG;
			RX_DUMP <= `HFDC_RST_FLAG;
			RECEIVE_ERROR_FLAG <= `HFDC_RST_FLAG;
		end else begin
			RECEIVE_ERROR_FLAG <= rx_err_set | (RECEIVE_ERROR_FLAG & ~RX_ERR_CLR);
			RX_DUMP <= RX_DUMP_SET;
			if (RX_DUMP) begin
				dwr_reg <= {DAW{1'b0}};
				drd_reg <= {DAW{1'b0}};
				swr_reg <= {SAW{1'b0}};
				srd_reg <= {SAW{1'b0}};
				RX_QUEUE_FILL_DATA <= {(DAW+1){1'b0}};
				RX_QUEUE_FILL_STAT <= {(SAW+1){1'b0}};
				RX_SKIP_HEAD_PACKET <= RX_SKIP_HEAD_PACKET_SET;
			end else begin
				RX_SKIP_HEAD_PACKET <= RX_SKIP_HEAD_PACKET_SET | (RX_SKIP_HEAD_PACKET & ~skip_done);
				if (d_wr)
					dwr_reg <= dwr_reg + {{(DAW-1){1'b0}}, 1'b1};
				if (d_rd)
					drd_reg <= drd_reg + {{(DAW-1){1'b0}}, 1'b1};
				if (s_wr)
					swr_reg <= swr_reg + {{(SAW-1){1'b0}}, 1'b1};
				if (host_s_rd)
					srd_reg <= srd_reg + {{(SAW-1){1'b0}}, 1'b1};
				if (d_wr && !d_rd)
					RX_QUEUE_FILL_DATA <= RX_QUEUE_FILL_DATA + {{DAW{1'b0}}, 1'b1};
				else if (d_rd && !d_wr)
					RX_QUEUE_FILL_DATA <= RX_QUEUE_FILL_DATA - {{DAW{1'b0}}, 1'b1};
				if (s_wr && !host_s_rd)
					RX_QUEUE_FILL_STAT <= RX_QUEUE_FILL_STAT + {{SAW{1'b0}}, 1'b1};
				else if (host_s_rd && !s_wr)
					RX_QUEUE_FILL_STAT <= RX_QUEUE_FILL_STAT - {{SAW{1'b0}}, 1'b1};
			end
			if (host_d_rd)
				RX_RDATA <= dmem[drd_reg][31:0];
			if (host_s_rd)
				RX_RSTAT <= smem[srd_reg];
		end
	end
endmodule // hfdc_top

// ### test_host_fifo_datapath_control.sv
// self-checking bench for the host fifo datapath control block
`timescale 1ns/1ps
module test_host_fifo_datapath_control;
	localparam DAW = 6;
	localparam SAW = 4;
	localparam BW = 4;
	reg CLK = 1'b0, ARST_N = 1'b0, TX_WR = 1'b0, TX_DFIFO_FULL = 1'b0, TX_STAT_PUSH = 1'b0, TX_STAT_FULL = 1'b0;
	reg TX_STATUS_DISCARD_ALLOW_OVERRUN = 1'b0, TX_ERR_CLR = 1'b0, TX_STOP_SET = 1'b0, TX_ON_SET = 1'b0;
	reg TX_FRAME_BUSY = 1'b0, RX_PAD_EN = 1'b0, RX_SKIP_HEAD_PACKET_SET = 1'b0, RX_DUMP_SET = 1'b0;
	reg HOST_RD_DATA = 1'b0, HOST_RD_STAT = 1'b0, RX_ERR_CLR = 1'b0, ok;
	reg [31:0] TX_WDATA = 32'h00000000;
	reg [4:0] RX_OFFSET = 5'h00;
	reg [1:0] lb;
	wire TRANSMIT_ERROR_FLAG, TX_ON, TX_STOP, TRANSMIT_HALTED_INTERRUPT, MAC_VALID, MAC_LAST, MAC_IS_STATUS, MAC_READY;
	wire RX_SKIP_HEAD_PACKET, RX_DUMP, RECEIVE_ERROR_FLAG;
	wire [31:0] MAC_DATA, RX_RDATA, RX_RSTAT;
	wire [1:0] MAC_LAST_BYTES;
	wire [DAW:0] RX_QUEUE_FILL_DATA;
	wire [SAW:0] RX_QUEUE_FILL_STAT;
	integer bad_count = 0, checks_done = 0, halts = 0, i, k, p, t, nw, ex;
	reg [31:0] pw [0:1][0:7];
	reg [31:0] ps [0:1];
	always #12.5 CLK = ~CLK;
	always @(negedge CLK) if (TRANSMIT_HALTED_INTERRUPT === 1'b1) halts = halts + 1;
	hfdc_top #(.DAW(DAW), .SAW(SAW), .RX_BURST_WORDS(8'h04)) hfdc_top_i (.*);
	hfdc_mac_model hfdc_mac_model_i (.*);
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", checks_done, bad_count);
			if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(negedge CLK);
		end
	endtask
	task tmo;
		begin
			bad_count = bad_count + 1;
			stop_test;
		end
	endtask
	task txw(input [31:0] w);
		begin
			TX_WDATA = w;
			TX_WR = 1'b1;
			cyc(1);
		end
	endtask
	task tx_buf(input [31:0] a, input [31:0] b);
		begin
			txw(a);
			txw(b);
			for (k = 0; k < (a[10:0] + 3) / 4; k = k + 1) txw($urandom);
		end
	endtask
	task tx_chk(input e);
		begin
			TX_WR = 1'b0;
			cyc(2);
			cmp(TRANSMIT_ERROR_FLAG, e);
			TX_ERR_CLR = 1'b1;
			cyc(1);
			TX_ERR_CLR = 1'b0;
			cmp(TRANSMIT_ERROR_FLAG, 0);
		end
	endtask
	task rd(input s);
		begin
			if (s) HOST_RD_STAT = 1'b1;
			else HOST_RD_DATA = 1'b1;
			cyc(1);
			HOST_RD_STAT = 1'b0;
			HOST_RD_DATA = 1'b0;
			cyc(1);
		end
	endtask
	function integer pkt_words(input integer n, input [1:0] b2, input [4:0] off, input pad);
		integer w, b;
		begin
			b = (b2 == 2'h0) ? 4 : b2;
			w = off[4:2] + n + ((off[1:0] != 2'h0 && b + off[1:0] > 4) ? 1 : 0);
			pkt_words = pad ? ((w + BW - 1) / BW) * BW : w;
		end
	endfunction
	function [31:0] exp_word(input integer pk, input integer kw, input integer n, input [4:0] off);
		integer q, j;
		begin
			exp_word = 32'h00000000;
			for (q = 0; q < 4; q = q + 1) begin
				j = 4 * kw + q - off;
				if (j >= 0 && j < 4 * n) exp_word[8*q +: 8] = pw[pk][j / 4][8*(j % 4) +: 8];
			end
		end
	endfunction
	initial begin
		i = $urandom(31516);
		cyc(10);
		ARST_N = 1'b1;
		cyc(1);
		t = $urandom_range(40, 1);
		tx_buf(32'h00003000 | t, t);
		tx_chk(0);
		tx_buf(32'h00003000 | t, t + 1);
		tx_chk(1);
		tx_buf(32'h00002008, t + 8);
		tx_buf(32'h00001000 | t, t + 8);
		tx_chk(0);
		tx_buf(32'h00002008, t + 8);
		tx_buf(32'h00001000 | t, t + 9);
		tx_chk(1);
		TX_DFIFO_FULL = 1'b1;
		txw(32'h00003004);
		TX_DFIFO_FULL = 1'b0;
		tx_chk(1);
		for (i = 0; i < 2; i = i + 1) begin
			TX_STAT_FULL = 1'b1;
			TX_STATUS_DISCARD_ALLOW_OVERRUN = i;
			TX_STAT_PUSH = 1'b1;
			cyc(1);
			TX_STAT_PUSH = 1'b0;
			tx_chk(!i);
		end
		TX_STAT_FULL = 1'b0;
		$display("test tx errors done");
		TX_FRAME_BUSY = 1'b1;
		TX_ON_SET = 1'b1;
		cyc(1);
		TX_ON_SET = 1'b0;
		TX_STOP_SET = 1'b1;
		cyc(1);
		TX_STOP_SET = 1'b0;
		cyc(3);
		cmp({TX_ON, TX_STOP, halts[7:0]}, 10'h300);
		TX_STAT_PUSH = 1'b1;
		cyc(1);
		TX_STAT_PUSH = 1'b0;
		cyc(2);
		cmp({TX_ON, TX_STOP, halts[7:0]}, 10'h001);
		TX_FRAME_BUSY = 1'b0;
		TX_ON_SET = 1'b1;
		cyc(1);
		TX_ON_SET = 1'b0;
		cmp(TX_ON, 1);
		TX_STOP_SET = 1'b1;
		cyc(1);
		TX_STOP_SET = 1'b0;
		cyc(3);
		cmp({TX_ON, TX_STOP, halts[7:0]}, 10'h002);
		$display("test tx stop done");
		rd(1);
		cmp(RECEIVE_ERROR_FLAG, 1);
		RX_ERR_CLR = 1'b1;
		cyc(1);
		RX_ERR_CLR = 1'b0;
		cmp(RECEIVE_ERROR_FLAG, 0);
		for (i = 0; i < 3; i = i + 1) begin
			RX_OFFSET = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : $urandom_range(31, 0);
			RX_PAD_EN = (i != 1);
			nw = $urandom_range(8, 4);
			lb = $urandom_range(3, 0);
			for (p = 0; p < 2; p = p + 1) begin
				for (k = 0; k < nw; k = k + 1) begin
					pw[p][k] = $urandom;
					if (k == nw - 1 && lb != 2'h0) pw[p][k] = pw[p][k] & ((32'h1 << (8 * lb)) - 1);
					hfdc_mac_model_i.send(pw[p][k], k == nw - 1, lb, 1'b0, ok);
					if (!ok) tmo;
				end
				ps[p] = $urandom;
				hfdc_mac_model_i.send(ps[p], 1'b0, 2'h0, 1'b1, ok);
				if (!ok) tmo;
			end
			hfdc_mac_model_i.idle;
			for (t = 0; t < 60 && RX_QUEUE_FILL_STAT !== 2; t = t + 1) cyc(1);
			if (t == 60) tmo;
			ex = pkt_words(nw, lb, RX_OFFSET, RX_PAD_EN);
			cmp(RX_QUEUE_FILL_DATA, 2 * ex);
			if (i == 2) begin
				RX_SKIP_HEAD_PACKET_SET = 1'b1;
				cyc(1);
				RX_SKIP_HEAD_PACKET_SET = 1'b0;
				for (t = 0; t < 60 && RX_SKIP_HEAD_PACKET !== 1'b0; t = t + 1) cyc(1);
				if (t == 60) tmo;
				cmp({RX_QUEUE_FILL_DATA, RX_QUEUE_FILL_STAT}, {ex[6:0], 5'h02});
			end
			for (p = 0; p < 2; p = p + 1) begin
				rd(1);
				cmp(RX_RSTAT, ps[p]);
			end
			for (p = (i == 2); p < 2; p = p + 1) begin
				for (k = 0; k < ex; k = k + 1) begin
					rd(0);
					cmp(RX_RDATA, exp_word(p, k, nw, RX_OFFSET));
				end
			end
			cmp(RX_QUEUE_FILL_DATA, 0);
		end
		$display("test rx packets done");
		RX_OFFSET = 5'h00;
		RX_PAD_EN = 1'b0;
		ok = 1'b1;
		for (k = 0; k < 80 && ok; k = k + 1) hfdc_mac_model_i.send(k, 1'b0, 2'h0, 1'b0, ok);
		hfdc_mac_model_i.idle;
		cmp({ok, RX_QUEUE_FILL_DATA}, 8'h40);
		for (p = 0; p < 3; p = p + 1) begin
			rd(0);
			cmp(RX_RDATA, p);
		end
		cyc(6);
		cmp(RX_QUEUE_FILL_DATA, 63);
		RX_DUMP_SET = 1'b1;
		cyc(1);
		RX_DUMP_SET = 1'b0;
		cyc(2);
		cmp({RX_QUEUE_FILL_DATA, RX_QUEUE_FILL_STAT}, 0);
		$display("test buffer and dump done");
		stop_test;
	end
	initial begin
		#2000000;
		tmo;
	end
endmodule // test_host_fifo_datapath_control
